// *** verilog/sarsq_pkg.sv ***
// Behaviour
// - each conversion takes eighteen conversion clocks minimum
// - results twelve bits, full rated throughput
// - eight pin inputs through one-at-a-time sequencer
// - scan steps channels autonomously, no idle gaps
// - switching by state machine or firmware writes
// - separate result buffer per channel
// - per-channel sample time applied when sampling
// - window compare raises out-of-range interrupt immediately
// - programmable sample-and-hold aperture length
// - reference select: supply, half, internal, external
// - temperature sensor selectable as input
// - converter stopped in three deepest sleep states
// - availability follows active low-power state
package sarsq_pkg;
   // register byte offsets
   localparam logic [7:0] SARSQ_CTRL_OFF   = 8'h00;
   localparam logic [7:0] SARSQ_CHEN_OFF   = 8'h04;
   localparam logic [7:0] SARSQ_FWCH_OFF   = 8'h08;
   localparam logic [7:0] SARSQ_LIMLO_OFF  = 8'h0c;
   localparam logic [7:0] SARSQ_LIMHI_OFF  = 8'h10;
   localparam logic [7:0] SARSQ_STAT_OFF   = 8'h14;
   localparam logic [7:0] SARSQ_ICLR_OFF   = 8'h18;
   localparam logic [7:0] SARSQ_IEN_OFF    = 8'h1c;
   localparam logic [7:0] SARSQ_STIME_OFF  = 8'h20; // 9 words, 0x20..0x40
   localparam logic [7:0] SARSQ_RES_OFF    = 8'h60; // 9 words, 0x60..0x80
   // control fields
   localparam int SARSQ_CTRL_EN    = 0;
   localparam int SARSQ_CTRL_FW    = 1;
   localparam int SARSQ_CTRL_START = 2; // write-one pulse
   localparam int SARSQ_CTRL_CONT  = 3;
   localparam int SARSQ_CTRL_REF   = 4; // two bits
   localparam int SARSQ_CTRL_DIV   = 8; // four bits
   localparam int SARSQ_CTRL_APER  = 12; // four bits
   localparam int SARSQ_STAT_BUSY  = 3;
   localparam int SARSQ_STAT_AVAIL = 4;
   // interrupt bits
   localparam int SARSQ_IRQ_DONE  = 0;
   localparam int SARSQ_IRQ_SCAN  = 1;
   localparam int SARSQ_IRQ_RANGE = 2;
   localparam int SARSQ_NIRQ      = 3;
   // reset values
   localparam logic [31:0] SARSQ_CTRL_RST  = 32'h0000_0100;
   localparam logic [11:0] SARSQ_LIMHI_RST = 12'hfff;
   localparam logic [7:0]  SARSQ_STIME_RST = 8'h03;
   // conversion timing
   localparam int SARSQ_CONV_CLKS = 18;
   localparam int SARSQ_BITS      = 12;
   localparam int SARSQ_NCH       = 8;
   localparam int SARSQ_TEMP_CH   = 8;
   localparam int SARSQ_CLK_MHZ   = 125;
   localparam real SARSQ_FCONV_MAX_MHZ = 14.5;
   // least divide so conversion clock stays at or under its maximum
   localparam int SARSQ_DIV_MIN =
      int'($ceil(SARSQ_CLK_MHZ / SARSQ_FCONV_MAX_MHZ));
   // reference choices
   typedef enum logic [1:0] {
      SARSQ_REF_VDD  = 2'b00,
      SARSQ_REF_HALF = 2'b01,
      SARSQ_REF_INT  = 2'b10,
      SARSQ_REF_EXT  = 2'b11
   } sarsq_ref_e;
   // power states
   typedef enum logic [2:0] {
      SARSQ_PWR_ACTIVE = 3'b000,
      SARSQ_PWR_SLEEP  = 3'b001,
      SARSQ_PWR_DEEP   = 3'b010,
      SARSQ_PWR_HIBER  = 3'b011,
      SARSQ_PWR_STOP   = 3'b100
   } sarsq_pwr_e;
   typedef enum logic [1:0] {
      SARSQ_ST_IDLE = 2'b00,
      SARSQ_ST_SAMP = 2'b01,
      SARSQ_ST_CONV = 2'b10
   } sarsq_st_e;
endpackage

// *** verilog/sarsq_top.sv ***
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
module sarsq_top
   import sarsq_pkg::*;
   (
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   input  wire logic [7:0]            paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [2:0]            pwr_state,
   output logic      [3:0]            mux_sel,
   output logic                       mux_temp_en,
   output logic      [1:0]            ref_sel,
   output logic                       sh_hold,
   output logic                       cmp_trial_en,
   output logic      [SARSQ_BITS-1:0] dac_code,
   input  wire logic                  cmp_out,
   output logic                       irq
   );

   typedef struct packed {
      logic [31:0]                 ctrl;
      logic [8:0]                  chen;
      logic [3:0]                  fwch;
      logic [11:0]                 limlo;
      logic [11:0]                 limhi;
      logic [SARSQ_NIRQ-1:0]       stat;
      logic [SARSQ_NIRQ-1:0]       ien;
      logic [8:0][7:0]             stime;
      logic [8:0][SARSQ_BITS-1:0]  res;
      sarsq_st_e                   st;
      logic [3:0]                  ch;
      logic [7:0]                  cnt;
      logic [3:0]                  div;
      logic [4:0]                  cyc;
      logic [SARSQ_BITS-1:0]       code;
      logic [31:0]                 rdata;
   } sarsq_state_s;

   sarsq_state_s s_reg;
   sarsq_state_s s_next;

   // lowest enabled channel at or above start, returns 4'hf for none
   function automatic logic [3:0] next_ch(input logic [8:0] en,
                                          input logic [4:0] start);
      logic [3:0] r;
      r = 4'hf;
      for (int i = 8; i >= 0; i--) begin
         if (en[i] && (5'(i) >= start)) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   logic       wr;
   logic       rd;
   logic       avail;
   logic       conv_tick;
   logic [3:0] nxt;
   logic [3:0] first;
   logic [7:0] samp_len;
   logic [4:0] lo_idx;
   logic [3:0] widx;
   logic [3:0] ridx;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign widx = 4'(paddr[7:2] - 6'(SARSQ_STIME_OFF >> 2));
   assign ridx = 4'(paddr[7:2] - 6'(SARSQ_RES_OFF >> 2));
   // power gating: deep sleep, hibernate, stop stop it
   assign avail = (pwr_state == SARSQ_PWR_ACTIVE) ||
                  (pwr_state == SARSQ_PWR_SLEEP);
   // conversion clock enable; divider floored so 14.5 MHz is never beaten
   assign conv_tick = (s_reg.div == 4'd0);
   assign lo_idx = 5'(s_reg.ch) + 5'd1;
   assign nxt = next_ch(s_reg.chen, lo_idx);
   assign first = next_ch(s_reg.chen, 5'd0);
   // per-channel time plus global aperture extension
   assign samp_len = s_reg.stime[s_reg.ch] +
                     {4'h0, s_reg.ctrl[SARSQ_CTRL_APER +: 4]};

   always_comb begin
      logic [3:0] dmax;
      logic [3:0] startch;
      logic       go;
      s_next = s_reg;
      dmax = s_reg.ctrl[SARSQ_CTRL_DIV +: 4];
      if (dmax < 4'(SARSQ_DIV_MIN - 1)) begin
         dmax = 4'(SARSQ_DIV_MIN - 1);
      end
      startch = first;
      go = 1'b0;
      s_next.ctrl[SARSQ_CTRL_START] = 1'b0;
      // divider runs only while converter is usable
      if (!avail || conv_tick) begin
         s_next.div = dmax;
      end else begin
         s_next.div = s_reg.div - 4'd1;
      end
      // apb register writes
      if (wr) begin
         case (paddr)
            SARSQ_CTRL_OFF: begin
               s_next.ctrl = pwdata;
               go = pwdata[SARSQ_CTRL_START];
            end
            SARSQ_CHEN_OFF:  s_next.chen = pwdata[8:0];
            // firmware picks channel by register write
            SARSQ_FWCH_OFF: begin
               s_next.fwch = (pwdata[3:0] > 4'd8) ? 4'd8 : pwdata[3:0];
               go = s_reg.ctrl[SARSQ_CTRL_FW];
            end
            SARSQ_LIMLO_OFF: s_next.limlo = pwdata[11:0];
            SARSQ_LIMHI_OFF: s_next.limhi = pwdata[11:0];
            SARSQ_ICLR_OFF:  s_next.stat = s_reg.stat &
                                           ~pwdata[SARSQ_NIRQ-1:0];
            SARSQ_IEN_OFF:   s_next.ien = pwdata[SARSQ_NIRQ-1:0];
            default: begin
               // bound by address, the narrow index wraps past the table
               if (paddr[1:0] == 2'b00 && paddr >= SARSQ_STIME_OFF &&
                   paddr <= SARSQ_STIME_OFF + 8'(4 * SARSQ_TEMP_CH)) begin
                  s_next.stime[widx] = (pwdata[7:0] == 8'h00) ?
                                       8'h01 : pwdata[7:0];
               end
            end
         endcase
      end
      // mode and enable of the very write that starts the sequencer
      if (s_next.ctrl[SARSQ_CTRL_FW]) begin
         startch = s_next.fwch;
      end
      // sequencer
      case (s_reg.st)
         SARSQ_ST_IDLE: begin
            if (go && avail && s_next.ctrl[SARSQ_CTRL_EN] &&
                startch != 4'hf) begin
               s_next.st = SARSQ_ST_SAMP;
               s_next.ch = startch;
               s_next.cnt = 8'h00;
            end
         end
         SARSQ_ST_SAMP: begin
            if (conv_tick) begin
               s_next.cnt = s_reg.cnt + 8'h01;
               if (s_reg.cnt + 8'h01 >= samp_len) begin
                  s_next.st = SARSQ_ST_CONV;
                  s_next.cyc = 5'd0;
                  s_next.code = {1'b1, {(SARSQ_BITS-1){1'b0}}};
               end
            end
         end
         SARSQ_ST_CONV: begin
            if (conv_tick) begin
               s_next.cyc = s_reg.cyc + 5'd1;
               // one bit trial per conversion clock
               if (s_reg.cyc < 5'(SARSQ_BITS)) begin
                  for (int b = 0; b < SARSQ_BITS; b++) begin
                     if (5'(SARSQ_BITS - 1 - b) == s_reg.cyc) begin
                        s_next.code[b] = cmp_out;
                     end
                     // next lower bit becomes the following trial
                     if (5'(SARSQ_BITS - 2 - b) == s_reg.cyc) begin
                        s_next.code[b] = 1'b1;
                     end
                  end
               end
               if (s_reg.cyc == 5'(SARSQ_CONV_CLKS - 1)) begin
                  s_next.res[s_reg.ch] = s_reg.code;
                  s_next.stat[SARSQ_IRQ_DONE] = 1'b1;
                  if (s_reg.code < s_reg.limlo ||
                      s_reg.code > s_reg.limhi) begin
                     s_next.stat[SARSQ_IRQ_RANGE] = 1'b1;
                  end
                  if (s_reg.ctrl[SARSQ_CTRL_FW]) begin
                     s_next.st = SARSQ_ST_IDLE;
                  end else begin
                     s_next.st = SARSQ_ST_SAMP;
                     s_next.cnt = 8'h00;
                     if (nxt != 4'hf) begin
                        s_next.ch = nxt;
                     end else begin
                        s_next.stat[SARSQ_IRQ_SCAN] = 1'b1;
                        s_next.ch = first;
                        if (!s_reg.ctrl[SARSQ_CTRL_CONT] ||
                            first == 4'hf) begin
                           s_next.st = SARSQ_ST_IDLE;
                        end
                     end
                  end
               end
            end
         end
         default: s_next.st = SARSQ_ST_IDLE;
      endcase
      // abort when clock source disappears or disabled
      if (!avail || !s_next.ctrl[SARSQ_CTRL_EN]) begin
         s_next.st = SARSQ_ST_IDLE;
      end
      // apb read data captured in setup so it is registered
      if (rd) begin
         case (paddr)
            SARSQ_CTRL_OFF:  s_next.rdata = s_reg.ctrl;
            SARSQ_CHEN_OFF:  s_next.rdata = {23'h0, s_reg.chen};
            SARSQ_FWCH_OFF:  s_next.rdata = {28'h0, s_reg.fwch};
            SARSQ_LIMLO_OFF: s_next.rdata = {20'h0, s_reg.limlo};
            SARSQ_LIMHI_OFF: s_next.rdata = {20'h0, s_reg.limhi};
            SARSQ_STAT_OFF:  s_next.rdata = {27'h0, avail,
                                 s_reg.st != SARSQ_ST_IDLE, s_reg.stat};
            SARSQ_IEN_OFF:   s_next.rdata = {29'h0, s_reg.ien};
            default: begin
               s_next.rdata = 32'h0;
               if (paddr[1:0] == 2'b00 && paddr >= SARSQ_STIME_OFF &&
                   paddr <= SARSQ_STIME_OFF + 8'(4 * SARSQ_TEMP_CH)) begin
                  s_next.rdata = {24'h0, s_reg.stime[widx]};
               end
               if (paddr[1:0] == 2'b00 && paddr >= SARSQ_RES_OFF &&
                   paddr <= SARSQ_RES_OFF + 8'(4 * SARSQ_TEMP_CH)) begin
                  s_next.rdata = {20'h0, s_reg.res[ridx]};
               end
            end
         endcase
      end
   end

   // single state register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_reg <= '0;
         s_reg.ctrl <= SARSQ_CTRL_RST;
         s_reg.limhi <= SARSQ_LIMHI_RST;
         s_reg.chen <= 9'h001;
         s_reg.stime <= {9{SARSQ_STIME_RST}};
         s_reg.st <= SARSQ_ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs toward the analog front end
   assign prdata = s_reg.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   // one input at a time, channel 8 is temperature
   assign mux_sel = s_reg.ch;
   assign mux_temp_en = (s_reg.ch == 4'(SARSQ_TEMP_CH));
   assign ref_sel = s_reg.ctrl[SARSQ_CTRL_REF +: 2];
   assign sh_hold = (s_reg.st == SARSQ_ST_CONV);
   assign cmp_trial_en = sh_hold && conv_tick;
   assign dac_code = s_reg.code;
   assign irq = |(s_reg.stat & s_reg.ien);
endmodule

// *** verification/sarsq_analog_model.sv ***
`timescale 1ns/1ns
// analog sources and comparator behind the input mux
module sarsq_analog_model (
   input  wire logic [8:0][11:0] levels,
   input  wire logic [3:0]       mux_sel,
   input  wire logic [11:0]      dac_code,
   output logic                  cmp_out
);
   // one input at a time
   // half-lsb offset so a trial equal to the level keeps its bit
   assign cmp_out = {levels[mux_sel], 1'b1} > {dac_code, 1'b0};
endmodule

// *** verification/sarsq_assertions.sv ***
`timescale 1ns/1ns
module sarsq_assertions (
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic [2:0]  pwr_state,
   input wire logic [3:0]  mux_sel,
   input wire logic        mux_temp_en,
   input wire logic        sh_hold,
   input wire logic        cmp_trial_en,
   input wire logic [11:0] dac_code,
   input wire logic        irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic [4:0] trials;
   // trial pulses seen since the hold phase began
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) trials <= 5'h00;
      else if (!sh_hold) trials <= 5'h00;
      else if (cmp_trial_en) trials <= trials + 5'h01;
   end
   sequence s_quiet;
      !cmp_trial_en [*8];
   endsequence
   a_trial_gap: assert property (cmp_trial_en |=> s_quiet)
      else $error("trial pulses closer than nine clocks");
   a_trial_count: assert property (trials <= 5'd18)
      else $error("more than eighteen trials in one hold");
   a_trial_hold: assert property (cmp_trial_en |-> sh_hold)
      else $error("trial pulse outside the hold phase");
   a_msb_first: assert property (cmp_trial_en && trials == 5'd0
      |-> dac_code == 12'h800) else $error("first trial is not msb");
   a_temp_sel: assert property (mux_temp_en == (mux_sel == 4'h8))
      else $error("temp enable disagrees with mux");
   a_hold_chan: assert property (sh_hold && $past(sh_hold)
      |-> $stable(mux_sel)) else $error("mux moved during hold");
   // a registered power input may take one extra clock
   a_sleep_stop: assert property (pwr_state >= 3'h2
      |-> ##2 !sh_hold && !cmp_trial_en) else $error("runs in deep sleep");
   a_apb_ready: assert property (psel && penable |-> pready)
      else $error("access phase stalled");
   a_irq_reset: assert property ($rose(reset_n) |-> !irq)
      else $error("irq high after reset");
endmodule
bind sarsq_top sarsq_assertions chk_u (
   .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pready(pready), .pwr_state(pwr_state), .mux_sel(mux_sel),
   .mux_temp_en(mux_temp_en), .sh_hold(sh_hold),
   .cmp_trial_en(cmp_trial_en), .dac_code(dac_code), .irq(irq));

// *** verification/tb_sar_adc_scan_sequencer.sv ***
`timescale 1ns/1ns
module tb_sar_adc_scan_sequencer;
   import sarsq_pkg::*;
   logic             clock = 1'b0;
   logic             reset_n = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0]      pwdata = 32'h0, prdata, rd;
   logic [2:0]       pwr_state = 3'h0;
   logic [3:0]       mux_sel;
   logic [1:0]       ref_sel;
   logic [11:0]      dac_code;
   logic             pready, pslverr, temp_en, sh_hold, trial, cmp_out, irq;
   logic [8:0][11:0] levels = '0;
   logic [7:0]       wa[4] = '{8'h1c, 8'h18, 8'h1c, 8'h18};
   logic [31:0]      wd[4] = '{32'h4, 32'h4, 32'h3, 32'h3};
   int               mismatches = 0, num_checks = 0, cyc = 0, gap = 0, g1;
   logic [3:0]       seen_ch[$];
   int               seen_gap[$];
   always #4 clock = ~clock;
   sarsq_top dut_u (.clock(clock), .reset_n(reset_n), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pwr_state(pwr_state), .mux_sel(mux_sel), .mux_temp_en(temp_en),
      .ref_sel(ref_sel), .sh_hold(sh_hold), .cmp_trial_en(trial),
      .dac_code(dac_code), .cmp_out(cmp_out), .irq(irq));
   sarsq_analog_model ana_u (.levels(levels), .mux_sel(mux_sel),
      .dac_code(dac_code), .cmp_out(cmp_out));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // log each hold entry with its sampling gap; also cut off a hang
   always @(posedge clock) begin
      cyc <= cyc + 1;
      gap <= sh_hold ? 0 : gap + 1;
      if (sh_hold && gap != 0) begin
         seen_ch.push_back(mux_sel);
         seen_gap.push_back(gap);
      end
      if (cyc == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   // poll status until one bit is set; the cycle ceiling bounds it
   task automatic wait_stat(input int b);
      do apb(1'b0, SARSQ_STAT_OFF, 32'h0); while (rd[b] !== 1'b1);
   endtask
   initial begin
      levels[0] = 12'h123;
      levels[2] = 12'hf00;
      levels[5] = 12'h7ff;
      levels[8] = 12'h456;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      rchk("ctrl", SARSQ_CTRL_OFF, SARSQ_CTRL_RST);
      rchk("chen", SARSQ_CHEN_OFF, 32'h1);
      rchk("stime", SARSQ_STIME_OFF, {24'h0, SARSQ_STIME_RST});
      apb(1'b1, 8'h44, 32'hffff_ffff);
      rchk("unmapped", 8'h44, 32'h0);
      chk("slverr", 32'h0, {31'h0, pslverr});
      $display("test reset done");
      apb(1'b1, SARSQ_CHEN_OFF, 32'h105);
      apb(1'b1, SARSQ_LIMLO_OFF, 32'h100);
      apb(1'b1, SARSQ_LIMHI_OFF, 32'he00);
      apb(1'b1, SARSQ_IEN_OFF, 32'h7);
      apb(1'b1, SARSQ_STIME_OFF + 8'h08, 32'ha);
      apb(1'b1, SARSQ_CTRL_OFF, 32'h135);
      wait_stat(SARSQ_IRQ_SCAN);
      chk("order", 32'h28, {20'h0, seen_ch[0], seen_ch[1],
          seen_ch[2]});
      // back-to-back channel sees only its own sample time
      g1 = int'(SARSQ_STIME_RST) * SARSQ_DIV_MIN;
      chk("no gap", 32'(g1), 32'(seen_gap[2]));
      g1 = seen_gap[1];
      chk("stime gap", 32'd63, 32'(g1 - seen_gap[2]));
      rchk("res0", SARSQ_RES_OFF, 32'h123);
      rchk("res2", SARSQ_RES_OFF + 8'h08, 32'hf00);
      rchk("res8", SARSQ_RES_OFF + 8'h20, 32'h456);
      chk("ref", {30'h0, SARSQ_REF_EXT}, {30'h0, ref_sel});
      rchk("stat", SARSQ_STAT_OFF, 32'h17);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, wa[i], wd[i]);
         @(negedge clock);
         chk("irq", {31'h0, ~i[0]}, {31'h0, irq});
      end
      $display("test scan done");
      seen_ch.delete();
      apb(1'b1, SARSQ_CTRL_OFF, 32'h2103);
      apb(1'b1, SARSQ_FWCH_OFF, 32'h5);
      wait_stat(SARSQ_IRQ_DONE);
      chk("fw chan", 32'h5, {28'h0, seen_ch[0]});
      rchk("res5", SARSQ_RES_OFF + 8'h14, 32'h7ff);
      seen_gap.delete();
      apb(1'b1, SARSQ_ICLR_OFF, 32'h7);
      apb(1'b1, SARSQ_CTRL_OFF, 32'h2135);
      wait_stat(SARSQ_IRQ_SCAN);
      chk("aperture", 32'd18, 32'(seen_gap[1] - g1));
      $display("test firmware done");
      apb(1'b1, SARSQ_ICLR_OFF, 32'h7);
      pwr_state <= 3'h2;
      apb(1'b1, SARSQ_FWCH_OFF, 32'h5);
      repeat (300) @(posedge clock);
      rchk("deep", SARSQ_STAT_OFF, 32'h0);
      for (int p = 4; p >= 0; p--) begin
         pwr_state <= 3'(p);
         apb(1'b0, SARSQ_STAT_OFF, 32'h0);
         chk("avail", {31'h0, p < 2},
             {31'h0, rd[SARSQ_STAT_AVAIL]});
      end
      $display("test power done");
      finish_test();
   end
endmodule
